// File: tpc_pkg.sv
/*
  tpc_pkg: offsets, field positions, reset values and enumerations for the
  test and page configuration register bank.
  assumes: 8-bit registers on a plain strobe port, 6-bit register address.
*/
package tpc_pkg;

  localparam int unsigned TPC_AW = 6;
  localparam int unsigned TPC_DW = 8;
  localparam int unsigned TPC_PW = 7;

  localparam logic [5:0] TPC_OFS_PAGE  = 6'h30;
  localparam logic [5:0] TPC_OFS_SEL1  = 6'h31;
  localparam logic [5:0] TPC_OFS_SEL2  = 6'h32;
  localparam logic [5:0] TPC_OFS_PINEN = 6'h33;

  localparam logic [7:0] TPC_RST_PAGE  = 8'h00;
  localparam logic [7:0] TPC_RST_SEL1  = 8'h00;
  localparam logic [7:0] TPC_RST_SEL2  = 8'h00;
  localparam logic [7:0] TPC_RST_PINEN = 8'h80;

  // page register fields
  localparam int unsigned TPC_PG_OVR   = 7;
  localparam int unsigned TPC_PG_NUM_H = 1;
  localparam int unsigned TPC_PG_NUM_L = 0;
  localparam logic [7:0]  TPC_PG_MASK  = 8'h83;

  // probe and secure clock fields
  localparam int unsigned TPC_S1_CLK_H = 5;
  localparam int unsigned TPC_S1_CLK_L = 4;
  localparam int unsigned TPC_S1_D1    = 3;
  localparam int unsigned TPC_S1_BIT_H = 2;
  localparam int unsigned TPC_S1_BIT_L = 0;

  // probe group and sequence fields
  localparam int unsigned TPC_S2_REORD = 7;
  localparam int unsigned TPC_S2_PN9   = 6;
  localparam int unsigned TPC_S2_PN15  = 5;
  localparam int unsigned TPC_S2_GRP_H = 4;
  localparam int unsigned TPC_S2_GRP_L = 0;

  // driver enable fields
  localparam int unsigned TPC_PE_SIDE  = 7;
  localparam int unsigned TPC_PE_DRV_H = 6;
  localparam int unsigned TPC_PE_DRV_L = 0;

  localparam logic [6:0] TPC_SPI_PINS  = 7'h1F;
  localparam int unsigned TPC_D1       = 1;

  // pseudo-random generators: x^9+x^5+1 and x^15+x^14+1
  localparam int unsigned TPC_PN9_TAP  = 4;
  localparam int unsigned TPC_PN15_TAP = 13;
  localparam logic [8:0]  TPC_PN9_SEED  = 9'h1FF;
  localparam logic [14:0] TPC_PN15_SEED = 15'h7FFF;

  typedef enum logic [1:0]
  {
    TPC_CLK_OFF,
    TPC_CLK_OSC,
    TPC_CLK_UART,
    TPC_CLK_RF
  } tpc_clk_src_e;

  typedef enum logic [1:0]
  {
    TPC_HIF_PARALLEL,
    TPC_HIF_SPI,
    TPC_HIF_UART,
    TPC_HIF_I2C
  } tpc_hif_e;

  typedef enum logic [1:0]
  {
    TPC_SEQ_IDLE,
    TPC_SEQ_ARMED,
    TPC_SEQ_SEND
  } tpc_seq_e;

endpackage : tpc_pkg

// File: tpc_prbs.sv
/*
  tpc_prbs: nine and fifteen bit pseudo-random generators.
  assumes: advance is a one-cycle bit-rate enable from the transmitter.
*/
`timescale 1ns/10ps
`default_nettype none
module tpc_prbs
  import tpc_pkg::*;
(
  input  wire logic mclk,
  input  wire logic reset,
  input  wire logic restart,
  input  wire logic advance,
  input  wire logic use_fifteen,
  output logic      seq_bit
);

  typedef struct packed
  {
    logic [8:0]  pn9;
    logic [14:0] pn15;
    logic        out;
  } tpc_prbs_s;

  tpc_prbs_s state_reg;
  tpc_prbs_s state_next;

  always_comb
  begin
    state_next = state_reg;
    if (restart)
    begin
      state_next.pn9  = TPC_PN9_SEED;
      state_next.pn15 = TPC_PN15_SEED;
      state_next.out  = 1'b0;
    end
    else if (advance)
    begin
      state_next.pn9  = {state_reg.pn9[7:0],
                         state_reg.pn9[8] ^ state_reg.pn9[TPC_PN9_TAP]};
      state_next.pn15 = {state_reg.pn15[13:0],
                         state_reg.pn15[14] ^
                         state_reg.pn15[TPC_PN15_TAP]};
      state_next.out  = use_fifteen ? state_reg.pn15[14]
                                    : state_reg.pn9[8];
    end
  end

  always_ff @(posedge mclk or posedge reset)
  begin
    if (reset)
      state_reg <= '{pn9: TPC_PN9_SEED, pn15: TPC_PN15_SEED, out: 1'b0};
    else
      state_reg <= state_next;
  end

  assign seq_bit = state_reg.out;

endmodule : tpc_prbs
`default_nettype wire

// File: tpc_probe_mux.sv
/*
  tpc_probe_mux: picks a test bus group, a probe bit and the reordered
  port image.
  assumes: test groups arrive flattened, eight bits each; combinational.
*/
`timescale 1ns/10ps
`default_nettype none
module tpc_probe_mux
  import tpc_pkg::*;
#(
  parameter int unsigned GROUPS = 32
)
(
  input  wire logic [GROUPS*8-1:0] test_groups,
  input  wire logic [4:0]          group_choice,
  input  wire logic [2:0]          bit_choice,
  input  wire logic                reorder,
  output logic [7:0]               group_value,
  output logic                     probe_bit,
  output logic [6:0]               port_image
);

  if (GROUPS < 1 || GROUPS > 32)
  begin : g_groups_bad
    $error("tpc_probe_mux: GROUPS must be 1..32");
  end

  always_comb
  begin
    group_value = 8'h00;
    if (32'(group_choice) < GROUPS)
      group_value = test_groups[group_choice*8 +: 8];
    probe_bit = group_value[bit_choice];
    if (reorder)
      // bus bits 6..0 land on D4,D3,D2,D6,D5,D0,D1
      port_image = {group_value[3], group_value[2], group_value[6],
                    group_value[5], group_value[4], group_value[0],
                    group_value[1]};
    else
      port_image = group_value[6:0];
  end

endmodule : tpc_probe_mux
`default_nettype wire

// File: tpc_regs.sv
/*
  tpc_regs: test, page override and port driver configuration bank.
  assumes: one 10 MHz clock, host interface type given by the host
  interface detector, send command pulse from the command decoder.
*/
// Operation
// - override set: page number supplies address bits A5 and A4
// - override clear: latched address alone forms the register address
// - page number is ignored unless override is set
// - secure clock source 00 off, 01 oscillator, 10 UART, 11 RF
// - secure-clock-on-D1 drives the selected secure clock onto D1; the code does so only with a serial host interface
// - probe bit choice picks the test bus bit sent to the probe pin
// - reorder maps test bus onto port as D4,D3,D2,D6,D5,D0,D1
// - bit 6 enables and starts the nine bit pseudo-random sequence
// - bit 5 enables and starts the fifteen bit pseudo-random sequence; the code runs the nine bit one instead when bit 6 is also set
// - sequence is transmitted only after the send command
// - probe group choice selects the observed test bus group
// - side-line enable clear disables both UART side lines
// - driver enable bit n enables output driver of pin Dn
// - driver enables act only with a serial host interface
// - SPI, or UART with side lines, leaves only D0 to D4 usable
// - driver enable register resets to 80h
// - secure-clock-on-D1 removes D1 from general pin use
`timescale 1ns/10ps
`default_nettype none
module tpc_regs
  import tpc_pkg::*;
#(
  parameter int unsigned GROUPS = 32
)
(
  input  wire logic                mclk,
  input  wire logic                reset,
  input  wire logic [5:0]          reg_addr,
  input  wire logic [7:0]          reg_wdata,
  input  wire logic                reg_wr,
  input  wire logic                reg_rd,
  output logic [7:0]               reg_rdata,
  input  wire logic [5:0]          latch_addr,
  input  wire logic [3:0]          pin_addr,
  output logic [5:0]               eff_addr,
  input  wire logic [1:0]          host_if,
  input  wire logic                clk_osc,
  input  wire logic                clk_uart,
  input  wire logic                clk_rf,
  output logic                     secure_clock,
  input  wire logic [GROUPS*8-1:0] test_groups,
  output logic                     probe_output_pin,
  output logic [7:0]               test_bus_value,
  input  wire logic                send_cmd,
  input  wire logic                tx_bit_en,
  input  wire logic                tx_stop,
  output logic                     tx_seq_active,
  output logic                     tx_seq_bit,
  input  wire logic [6:0]          port_value,
  input  wire logic                port_general_io_enable,
  output logic [6:0]               port_out,
  output logic [6:0]               port_oe,
  output logic                     uart_side_line_a,
  output logic                     uart_side_line_b,
  input  wire logic                side_a_value,
  input  wire logic                side_b_value
);

  // the five-bit group choice cannot reach past 32 groups
  if (GROUPS < 1 || GROUPS > 32)
  begin : g_groups_bad
    $error("tpc_regs: GROUPS must be 1..32");
  end

  typedef struct packed
  {
    logic [7:0]  page;
    logic [7:0]  sel1;
    logic [7:0]  sel2;
    logic [7:0]  pinen;
    logic [7:0]  rdata;
    logic [5:0]  eaddr;
    logic        sclk;
    logic        probe;
    logic [7:0]  tbus;
    tpc_seq_e    seq;
    logic        act;
    logic        sbit;
    logic [6:0]  pout;
    logic [6:0]  poe;
    logic        side_a;
    logic        side_b;
  } tpc_regs_s;

  tpc_regs_s st_reg;
  tpc_regs_s st_next;

  logic [7:0] grp_value;
  logic       probe_bit;
  logic [6:0] port_image;
  logic       seq_bit;
  logic       seq_restart;

  function automatic logic [7:0] read_mux(input tpc_regs_s s,
                                          input logic [5:0] a);
    begin
      case (a)
        TPC_OFS_PAGE:  read_mux = s.page & TPC_PG_MASK;
        TPC_OFS_SEL1:  read_mux = s.sel1;
        TPC_OFS_SEL2:  read_mux = s.sel2;
        TPC_OFS_PINEN: read_mux = s.pinen;
        default:       read_mux = 8'h00;
      endcase
    end
  endfunction : read_mux

  tpc_probe_mux #(.GROUPS(GROUPS)) u_mux
  (
    .test_groups  (test_groups),
    .group_choice (st_reg.sel2[TPC_S2_GRP_H:TPC_S2_GRP_L]),
    .bit_choice   (st_reg.sel1[TPC_S1_BIT_H:TPC_S1_BIT_L]),
    .reorder      (st_reg.sel2[TPC_S2_REORD]),
    .group_value  (grp_value),
    .probe_bit    (probe_bit),
    .port_image   (port_image)
  );

  // generator reseeds whenever no sequence mode is selected
  assign seq_restart = !(st_reg.sel2[TPC_S2_PN9] ||
                         st_reg.sel2[TPC_S2_PN15]);

  tpc_prbs u_prbs
  (
    .mclk        (mclk),
    .reset       (reset),
    .restart     (seq_restart),
    .advance     (st_reg.seq == TPC_SEQ_SEND && tx_bit_en),
    .use_fifteen (st_reg.sel2[TPC_S2_PN15] && !st_reg.sel2[TPC_S2_PN9]),
    .seq_bit     (seq_bit)
  );

  always_comb
  begin
    logic       serial_if;
    logic       d1_clock;
    logic [6:0] usable;
    logic       clk_sel;
    serial_if = 1'b0;
    d1_clock  = 1'b0;
    usable    = '1;
    clk_sel   = 1'b0;
    st_next   = st_reg;

    if (reg_wr)
    begin
      case (reg_addr)
        TPC_OFS_PAGE:  st_next.page  = reg_wdata & TPC_PG_MASK;
        TPC_OFS_SEL1:  st_next.sel1  = reg_wdata;
        TPC_OFS_SEL2:  st_next.sel2  = reg_wdata;
        TPC_OFS_PINEN: st_next.pinen = reg_wdata;
        default:       st_next.pinen = st_reg.pinen;
      endcase
    end
    st_next.rdata = reg_rd ? read_mux(st_reg, reg_addr) : 8'h00;

    // page override replaces the top two address bits; with a parallel host the low four come from pin_addr
    if (st_reg.page[TPC_PG_OVR])
      st_next.eaddr = {st_reg.page[TPC_PG_NUM_H:TPC_PG_NUM_L],
                       (host_if == TPC_HIF_PARALLEL) ? pin_addr
                                                     : latch_addr[3:0]};
    else
      st_next.eaddr = latch_addr;

    // clocks sampled as levels; a real part uses a glitch-free clock mux
    case (tpc_clk_src_e'(st_reg.sel1[TPC_S1_CLK_H:TPC_S1_CLK_L]))
      TPC_CLK_OFF:  clk_sel = 1'b0;
      TPC_CLK_OSC:  clk_sel = clk_osc;
      TPC_CLK_UART: clk_sel = clk_uart;
      TPC_CLK_RF:   clk_sel = clk_rf;
      default:      clk_sel = 1'b0;
    endcase
    st_next.sclk  = clk_sel;
    st_next.probe = probe_bit;
    st_next.tbus  = grp_value;

    // sequence waits in armed until the send command
    case (st_reg.seq)
      TPC_SEQ_IDLE:
        if (!seq_restart)
          st_next.seq = TPC_SEQ_ARMED;
      TPC_SEQ_ARMED:
        if (seq_restart)
          st_next.seq = TPC_SEQ_IDLE;
        else if (send_cmd)
          st_next.seq = TPC_SEQ_SEND;
      TPC_SEQ_SEND:
        if (seq_restart)
          st_next.seq = TPC_SEQ_IDLE;
        else if (tx_stop)
          st_next.seq = TPC_SEQ_ARMED;
      default:
        st_next.seq = TPC_SEQ_IDLE;
    endcase
    // flag kept in its own flop so the port comes straight from a register
    st_next.act  = (st_next.seq == TPC_SEQ_SEND);
    st_next.sbit = (st_reg.seq == TPC_SEQ_SEND) ? seq_bit : 1'b0;

    serial_if = (host_if != TPC_HIF_PARALLEL);
    // the parallel interface case is left to the host
    d1_clock  = st_reg.sel1[TPC_S1_D1] && serial_if;
    if (host_if == TPC_HIF_SPI ||
        (host_if == TPC_HIF_UART && st_reg.pinen[TPC_PE_SIDE]))
      usable = TPC_SPI_PINS;

    st_next.poe  = '0;
    st_next.pout = port_image;
    if (serial_if)
    begin
      st_next.poe  = st_reg.pinen[TPC_PE_DRV_H:TPC_PE_DRV_L]
                     & usable;
      if (port_general_io_enable)
        st_next.pout = port_value;
    end
    if (d1_clock)
    begin
      st_next.poe[TPC_D1]  = 1'b1;
      st_next.pout[TPC_D1] = clk_sel;
    end

    st_next.side_a = st_reg.pinen[TPC_PE_SIDE] && side_a_value;
    st_next.side_b = st_reg.pinen[TPC_PE_SIDE] && side_b_value;
  end

  always_ff @(posedge mclk or posedge reset)
  begin
    if (reset)
    begin
      st_reg       <= '0;
      st_reg.page  <= TPC_RST_PAGE;
      st_reg.sel1  <= TPC_RST_SEL1;
      st_reg.sel2  <= TPC_RST_SEL2;
      st_reg.pinen <= TPC_RST_PINEN;
      st_reg.seq   <= TPC_SEQ_IDLE;
    end
    else
      st_reg <= st_next;
  end

  assign reg_rdata        = st_reg.rdata;
  assign eff_addr         = st_reg.eaddr;
  assign secure_clock     = st_reg.sclk;
  assign probe_output_pin = st_reg.probe;
  assign test_bus_value   = st_reg.tbus;
  assign tx_seq_active    = st_reg.act;
  assign tx_seq_bit       = st_reg.sbit;
  assign port_out         = st_reg.pout;
  assign port_oe          = st_reg.poe;
  assign uart_side_line_a = st_reg.side_a;
  assign uart_side_line_b = st_reg.side_b;

endmodule : tpc_regs
`default_nettype wire

// File: tpc_regs_checker.sv
/*
  tpc_regs_checker: port-level assertions for the test and page bank.
  assumes: bound into tpc_regs, one clock, async active-high reset.
*/
`timescale 1ns/10ps
`default_nettype none
module tpc_regs_checker
  import tpc_pkg::*;
#(
  parameter int unsigned GROUPS = 32
)
(
  input wire logic                mclk,
  input wire logic                reset,
  input wire logic [5:0]          reg_addr,
  input wire logic [7:0]          reg_wdata,
  input wire logic                reg_wr,
  input wire logic                reg_rd,
  input wire logic [7:0]          reg_rdata,
  input wire logic [5:0]          latch_addr,
  input wire logic [3:0]          pin_addr,
  input wire logic [5:0]          eff_addr,
  input wire logic [1:0]          host_if,
  input wire logic                clk_osc,
  input wire logic                clk_uart,
  input wire logic                clk_rf,
  input wire logic                secure_clock,
  input wire logic [GROUPS*8-1:0] test_groups,
  input wire logic                probe_output_pin,
  input wire logic                send_cmd,
  input wire logic                tx_seq_active,
  input wire logic [6:0]          port_oe,
  input wire logic                uart_side_line_a,
  input wire logic                side_a_value
);
  // shadow copies of the bank, kept from the write strobes alone
  logic [7:0] pg;
  logic [7:0] s1;
  logic [7:0] s2;
  logic [7:0] pe;
  logic [7:0] ix;
  logic [5:0] ea;
  logic       selc;
  logic       tbit;
  logic       side_x;

  always_ff @(posedge mclk or posedge reset)
    if (reset)
    begin
      pg <= 8'h00;
      s1 <= 8'h00;
      s2 <= 8'h00;
      pe <= 8'h80;
    end
    else if (reg_wr)
    begin
      if (reg_addr == 6'h30) pg <= reg_wdata & 8'h83;
      if (reg_addr == 6'h31) s1 <= reg_wdata;
      if (reg_addr == 6'h32) s2 <= reg_wdata;
      if (reg_addr == 6'h33) pe <= reg_wdata;
    end

  assign ea = pg[7] ? {pg[1:0], (host_if == TPC_HIF_PARALLEL) ?
              pin_addr : latch_addr[3:0]} : latch_addr;
  assign selc = (s1[5:4] == 2'b01) ? clk_osc :
                (s1[5:4] == 2'b10) ? clk_uart : (s1[5] & s1[4] & clk_rf);
  assign ix = {s2[4:0], s1[2:0]};
  // groups past GROUPS read zero, so the index is guarded
  assign tbit = (int'(ix) < GROUPS * 8) ? test_groups[ix] : 1'b0;
  assign side_x = side_a_value & pe[7];

  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);

  a_rdata_idle: assert property (reg_rdata != 8'h00 |-> $past(reg_rd))
    else $error("read data outside read slot");
  a_page_read: assert property ($past(reg_rd)
    && $past(reg_addr) == 6'h30 |-> reg_rdata == $past(pg))
    else $error("page register readback wrong");
  a_pinen_read: assert property ($past(reg_rd)
    && $past(reg_addr) == 6'h33 |-> reg_rdata == $past(pe))
    else $error("driver enable readback wrong");
  // the release edge still sees reset, so the bank only moves one edge later
  a_eff_addr: assert property (!reset |=> eff_addr == $past(ea))
    else $error("effective address wrong");
  a_clk_select: assert property (!reset |=> secure_clock == $past(selc))
    else $error("secure clock source wrong");
  a_probe_bit: assert property (!reset
    |=> probe_output_pin == $past(tbit))
    else $error("probe bit wrong");
  a_drv_parallel: assert property (host_if == TPC_HIF_PARALLEL
    |=> port_oe == 7'h00)
    else $error("drivers on with parallel host");
  a_drv_spi: assert property (host_if == TPC_HIF_SPI && !s1[3]
    |=> {1'b0, port_oe} == ($past(pe) & 8'h1F))
    else $error("driver enables wrong under spi");
  a_d1_clock: assert property (host_if != TPC_HIF_PARALLEL && s1[3]
    |=> port_oe[1])
    else $error("secure clock not driven on d1");
  a_side_line: assert property (!reset
    |=> uart_side_line_a == $past(side_x))
    else $error("side line enable ignored");
  a_seq_send: assert property ($rose(tx_seq_active)
    |-> $past(send_cmd))
    else $error("sequence sent without send command");
  a_seq_off: assert property (s2[6:5] == 2'b00 |=> !tx_seq_active)
    else $error("sequence active while disabled");
endmodule : tpc_regs_checker

bind tpc_regs tpc_regs_checker #(.GROUPS(GROUPS)) chk (.*);
`default_nettype wire

// File: tpc_regs_tb.sv
/*
  tpc_regs_tb: directed scenarios for the test and page bank.
  assumes: tpc_regs with four test groups, checker bound separately.
*/
`timescale 1ns/10ps
`default_nettype none
module tpc_regs_tb
  import tpc_pkg::*;
;
  localparam int G = 4;
  logic            mclk, reset, reg_wr, reg_rd, clk_osc, clk_uart, clk_rf;
  logic            send_cmd, tx_bit_en, tx_stop, port_general_io_enable;
  logic            side_a_value, side_b_value, secure_clock;
  logic            probe_output_pin, tx_seq_active, tx_seq_bit;
  logic            uart_side_line_a, uart_side_line_b;
  logic [5:0]      reg_addr, latch_addr, eff_addr;
  logic [7:0]      reg_wdata, reg_rdata, test_bus_value, v;
  logic [3:0]      pin_addr;
  logic [1:0]      host_if;
  logic [G*8-1:0]  test_groups;
  logic [6:0]      port_value, port_out, port_oe;
  int              fail_count;
  int              total_checks;

  tpc_regs #(.GROUPS(G)) uut (.*);

  always #50 mclk = ~mclk;

  task chk(input logic [7:0] s, input logic [7:0] e);
    total_checks++;
    if (s !== e)
    begin
      fail_count++;
      $display("BAD t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask : chk

  task wr(input logic [5:0] a, input logic [7:0] d);
    @(posedge mclk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask : wr

  // read data stand one cycle only, so sample just after that edge
  task rd(input logic [5:0] a);
    @(posedge mclk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1 v = reg_rdata;
  endtask : rd

  task settle;
    repeat (2) @(posedge mclk);
    #1;
  endtask : settle

  task snd;
    @(posedge mclk) send_cmd <= 1'b1;
    @(posedge mclk) send_cmd <= 1'b0;
  endtask : snd

  task t_reset;
    rd(6'h30);
    chk(v, 8'h00);
    rd(6'h31);
    chk(v, 8'h00);
    rd(6'h32);
    chk(v, 8'h00);
    rd(6'h33);
    chk(v, 8'h80);
    wr(6'h2F, 8'hFF);
    rd(6'h2F);
    chk(v, 8'h00);
  endtask : t_reset

  task t_page;
    wr(6'h30, 8'hFF);
    rd(6'h30);
    chk(v, 8'h83);
    settle;
    chk(8'(eff_addr), 8'h3A);
    @(posedge mclk) host_if <= TPC_HIF_PARALLEL;
    settle;
    chk(8'(eff_addr), 8'h35);
    wr(6'h30, 8'h03);
    settle;
    chk(8'(eff_addr), 8'h2A);
    @(posedge mclk) host_if <= TPC_HIF_SPI;
  endtask : t_page

  task t_clock;
    for (int s = 0; s < 4; s++)
    begin
      @(posedge mclk);
      clk_osc <= (s == 1);
      clk_uart <= (s == 2);
      clk_rf <= (s == 3);
      wr(6'h31, 8'(s << 4));
      settle;
      chk(8'(secure_clock), 8'(s != 0));
    end
    wr(6'h31, 8'h38);
    settle;
    chk(8'(port_oe), 8'h02);
    chk(8'(port_out[1]), 8'h01);
  endtask : t_clock

  task t_probe;
    wr(6'h32, 8'h82);
    wr(6'h31, 8'h05);
    settle;
    chk(test_bus_value, 8'h3C);
    chk(8'(probe_output_pin), 8'h01);
    chk(8'(port_out), 8'h6C);
    wr(6'h32, 8'h05);
    settle;
    chk(test_bus_value, 8'h00);
  endtask : t_probe

  task t_pins;
    wr(6'h33, 8'hFF);
    for (int i = 0; i < 4; i++)
    begin
      @(posedge mclk) host_if <= 2'(i);
      settle;
      chk(8'(port_oe), (i == 0) ? 8'h00 : (i == 3) ? 8'h7F : 8'h1F);
    end
    chk(8'(uart_side_line_a), 8'h01);
    wr(6'h33, 8'h7F);
    @(posedge mclk) host_if <= TPC_HIF_UART;
    settle;
    chk(8'(port_oe), 8'h7F);
    chk(8'({uart_side_line_a, uart_side_line_b}), 8'h00);
    @(posedge mclk) port_general_io_enable <= 1'b1;
    settle;
    chk(8'(port_out), 8'h55);
    wr(6'h31, 8'h38);
    settle;
    chk(8'(port_out), 8'h57);
  endtask : t_pins

  // transmit setup is assumed done before the mode bit is set
  task t_seq;
    wr(6'h32, 8'h40);
    settle;
    chk(8'(tx_seq_active), 8'h00);
    chk(8'(tx_seq_bit), 8'h00);
    snd;
    settle;
    chk(8'(tx_seq_active), 8'h01);
    @(posedge mclk) tx_bit_en <= 1'b1;
    @(posedge mclk) tx_bit_en <= 1'b0;
    settle;
    chk(8'(tx_seq_bit), 8'(TPC_PN9_SEED[8]));
    @(posedge mclk) tx_stop <= 1'b1;
    @(posedge mclk) tx_stop <= 1'b0;
    wr(6'h32, 8'h20);
    snd;
    settle;
    chk(8'(tx_seq_active), 8'h01);
    wr(6'h32, 8'h00);
    settle;
    chk(8'(tx_seq_active), 8'h00);
  endtask : t_seq

  task wrap_up;
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : wrap_up

  initial
  begin
    #1000000;
    fail_count++;
    wrap_up;
  end

  initial
  begin
    {mclk, reg_wr, reg_rd, clk_osc, clk_uart, clk_rf} = 6'h00;
    {send_cmd, tx_bit_en, tx_stop, port_general_io_enable} = 4'h0;
    {side_a_value, side_b_value} = 2'b11;
    reset = 1'b1;
    reg_addr = 6'h00;
    reg_wdata = 8'h00;
    latch_addr = 6'h2A;
    pin_addr = 4'h5;
    host_if = TPC_HIF_SPI;
    test_groups = 32'h963CC3A5;
    port_value = 7'h55;
    repeat (5) @(posedge mclk);
    reset <= 1'b0;
    t_reset;
    t_page;
    t_clock;
    t_probe;
    t_pins;
    t_seq;
    wrap_up;
  end
endmodule : tpc_regs_tb
`default_nettype wire
